// ### rtl/sbx_pkg.sv
// Shared constants for the SPI byte exchange master.
package sbx_pkg;
  localparam int DATA_W = 8;
  localparam int BIT_COUNT = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 5;
  // Divide ratios of the serial clock against mclk, indexed by rate field.
  localparam logic [5:0] DIV_SEL0 = 6'h02;
  localparam logic [5:0] DIV_SEL1 = 6'h04;
  localparam logic [5:0] DIV_SEL2 = 6'h10;
  localparam logic [5:0] DIV_SEL3 = 6'h20;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam logic POL_RESET = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Slave needs 43 of its own cycles per bit; no check or other code in the project refers to it.
  localparam int SLAVE_CYCLES_PER_BIT = 43;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEL = 4'b0010,
    ST_LOW = 4'b0100,
    ST_HIGH = 4'b1000
  } sbx_state_e;
endpackage

// ### rtl/sbx_fifo.sv
// Parameterised valid/ready FIFO for outgoing bytes.
`timescale 1ns/10ps
module sbx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [WIDTH-1:0] outData_r;
  logic full, empty, doWr, doRd;

  always_comb begin
    full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
    empty = (wrPtr_r == rdPtr_r);
    doWr = inValid && !full;
    doRd = outReady && !empty;
    wrPtr_nxt = wrPtr_r + (AW+1)'(doWr);
    rdPtr_nxt = rdPtr_r + (AW+1)'(doRd);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  // Show-ahead read: the head word is combinational from the array.
  assign outData_r = mem[rdPtr_r[AW-1:0]];
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = outData_r;
endmodule

// ### rtl/sbx_master.sv
// SPI byte exchange master with transmit FIFO and rate divider.
`timescale 1ns/10ps
module sbx_master #(
  parameter int DATA_W = sbx_pkg::DATA_W,
  parameter int FIFO_DEPTH = sbx_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [DATA_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  input wire logic rateSelectHi,
  input wire logic rateSelectLo,
  input wire logic clockIdlePolarity,
  input wire logic slaveRequest,
  input wire logic transferCompleteClear,
  output logic peerRequest_r,
  output logic sck_r,
  output logic mosi_r,
  input wire logic miso,
  output logic slaveSelectN_r,
  output logic transferCompleteFlag_r,
  output logic busy_r,
  output logic [DATA_W-1:0] rxData_r
);
  logic [DATA_W-1:0] fifoData;
  logic fifoValid, fifoReady;

  sbx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) txFifo (
    .mclk(mclk),
    .rst(rst),
    .inData(txData),
    .inValid(txValid),
    .inReady(txReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoReady)
  );

  sbx_pkg::sbx_state_e state_r, state_nxt;
  logic [DATA_W-1:0] shift_r, shift_nxt, rx_r, rx_nxt, rxData_nxt;
  logic [3:0] bitCounter_r, bitCounter_nxt;
  logic [5:0] divCnt_r, divCnt_nxt, halfDiv;
  logic sck_nxt, mosi_nxt, ss_nxt, flag_nxt, busy_nxt, req_nxt;
  logic halfTick;

  always_comb begin
    // The slowest ratio is kept so that a slow software slave can finish each bit.
    unique case ({rateSelectHi, rateSelectLo})
      2'h0: halfDiv = sbx_pkg::DIV_SEL0 >> 1;
      2'h1: halfDiv = sbx_pkg::DIV_SEL1 >> 1;
      2'h2: halfDiv = sbx_pkg::DIV_SEL2 >> 1;
      2'h3: halfDiv = sbx_pkg::DIV_SEL3 >> 1;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    rx_nxt = rx_r;
    rxData_nxt = rxData_r;
    bitCounter_nxt = bitCounter_r;
    divCnt_nxt = divCnt_r;
    sck_nxt = sck_r;
    mosi_nxt = mosi_r;
    ss_nxt = slaveSelectN_r;
    flag_nxt = transferCompleteFlag_r;
    busy_nxt = busy_r;
    req_nxt = peerRequest_r;
    fifoReady = 1'b0;
    halfTick = (divCnt_r == halfDiv - 6'h01);
    // Hardware set wins over a same-cycle clear.
    if (transferCompleteClear) begin
      flag_nxt = 1'b0;
    end
    unique case (state_r)
      sbx_pkg::ST_IDLE: begin
        sck_nxt = clockIdlePolarity;
        divCnt_nxt = '0;
        // Start as soon as a byte is in the FIFO, whether or not the slave has asked.
        if (fifoValid) begin
          req_nxt = 1'b1;
          ss_nxt = 1'b0;
          busy_nxt = 1'b1;
          fifoReady = 1'b1;
          shift_nxt = fifoData;
          state_nxt = sbx_pkg::ST_SEL;
        end
      end
      sbx_pkg::ST_SEL: begin
        // Select settles one cycle ahead of the first data bit.
        bitCounter_nxt = sbx_pkg::BITS_PER_BYTE;
        mosi_nxt = shift_r[DATA_W-1];
        shift_nxt = {shift_r[DATA_W-2:0], 1'b0};
        state_nxt = sbx_pkg::ST_LOW;
      end
      sbx_pkg::ST_LOW: begin
        divCnt_nxt = divCnt_r + 6'h01;
        if (halfTick) begin
          divCnt_nxt = '0;
          rx_nxt = {rx_r[DATA_W-2:0], miso};
          sck_nxt = ~clockIdlePolarity;
          state_nxt = sbx_pkg::ST_HIGH;
        end
      end
      sbx_pkg::ST_HIGH: begin
        divCnt_nxt = divCnt_r + 6'h01;
        if (halfTick) begin
          divCnt_nxt = '0;
          sck_nxt = clockIdlePolarity;
          bitCounter_nxt = bitCounter_r - 4'h1;
          if (bitCounter_r == 4'h1) begin
            rxData_nxt = rx_r;
            flag_nxt = 1'b1;
            busy_nxt = 1'b0;
            ss_nxt = 1'b1;
            req_nxt = 1'b0;
            state_nxt = sbx_pkg::ST_IDLE;
          end else begin
            mosi_nxt = shift_r[DATA_W-1];
            shift_nxt = {shift_r[DATA_W-2:0], 1'b0};
            state_nxt = sbx_pkg::ST_LOW;
          end
        end
      end
      default: state_nxt = sbx_pkg::ST_IDLE;
    endcase
    // A pending slave request is echoed on the request line while idle.
    if (state_r == sbx_pkg::ST_IDLE && !fifoValid) begin
      req_nxt = slaveRequest;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= sbx_pkg::ST_IDLE;
      shift_r <= sbx_pkg::DATA_RESET;
      rx_r <= sbx_pkg::DATA_RESET;
      rxData_r <= sbx_pkg::DATA_RESET;
      bitCounter_r <= '0;
      divCnt_r <= '0;
      sck_r <= sbx_pkg::POL_RESET;
      mosi_r <= 1'b0;
      slaveSelectN_r <= 1'b1;
      transferCompleteFlag_r <= 1'b0;
      busy_r <= 1'b0;
      peerRequest_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      rx_r <= rx_nxt;
      rxData_r <= rxData_nxt;
      bitCounter_r <= bitCounter_nxt;
      divCnt_r <= divCnt_nxt;
      sck_r <= sck_nxt;
      mosi_r <= mosi_nxt;
      slaveSelectN_r <= ss_nxt;
      transferCompleteFlag_r <= flag_nxt;
      busy_r <= busy_nxt;
      peerRequest_r <= req_nxt;
    end
  end

  // Assertions.
  idle_clock_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == sbx_pkg::ST_IDLE && $past(state_r) == sbx_pkg::ST_IDLE
     && $stable(clockIdlePolarity)) |-> sck_r == clockIdlePolarity)
    else $error("serial clock not at idle level");
  select_first_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(busy_r) |-> !slaveSelectN_r ##1 !sck_r == !clockIdlePolarity)
    else $error("select not low at start");
  done_flag_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(busy_r) |-> transferCompleteFlag_r && slaveSelectN_r)
    else $error("flag not set at end");
  busy_flag_a: assert property (@(posedge mclk) disable iff (rst)
    busy_r |-> state_r != sbx_pkg::ST_IDLE)
    else $error("busy while idle");
  start_write_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(busy_r) |-> $past(fifoValid))
    else $error("start without data");
  bit_count_a: assert property (@(posedge mclk) disable iff (rst)
    busy_r |-> bitCounter_r <= sbx_pkg::BITS_PER_BYTE)
    else $error("bit counter out of range");
  request_a: assert property (@(posedge mclk) disable iff (rst)
    busy_r |-> peerRequest_r)
    else $error("transfer without request");
  rate_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == sbx_pkg::ST_LOW && divCnt_r == '0 && !halfTick && $stable(halfDiv))
    |-> ##1 divCnt_r == 6'h01)
    else $error("divider not counting");
  mosi_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == sbx_pkg::ST_LOW && $past(state_r) == sbx_pkg::ST_LOW) |-> $stable(mosi_r))
    else $error("data out moved inside a bit");
  clock_active_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == sbx_pkg::ST_HIGH && $stable(clockIdlePolarity))
    |-> sck_r != clockIdlePolarity)
    else $error("serial clock not active in high phase");
  rx_capture_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == sbx_pkg::ST_LOW && halfTick) |=> rx_r[0] == $past(miso))
    else $error("data in not captured at leading edge");
  count_load_a: assert property (@(posedge mclk) disable iff (rst)
    state_r == sbx_pkg::ST_SEL |=> bitCounter_r == sbx_pkg::BITS_PER_BYTE)
    else $error("bit counter not loaded");
  flag_set_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == sbx_pkg::ST_HIGH && halfTick && bitCounter_r == 4'h1)
    |=> transferCompleteFlag_r && rxData_r == $past(rx_r))
    else $error("flag or received byte wrong at end");
  flag_clear_a: assert property (@(posedge mclk) disable iff (rst)
    (transferCompleteClear && !(state_r == sbx_pkg::ST_HIGH && halfTick
     && bitCounter_r == 4'h1)) |=> !transferCompleteFlag_r)
    else $error("flag not cleared");
  select_hold_a: assert property (@(posedge mclk) disable iff (rst)
    busy_r |-> !slaveSelectN_r)
    else $error("select released during exchange");
  half_period_a: assert property (@(posedge mclk) disable iff (rst)
    ((state_r == sbx_pkg::ST_LOW || state_r == sbx_pkg::ST_HIGH) && $stable(halfDiv))
    |-> divCnt_r < halfDiv)
    else $error("divider beyond half period");
  start_c: cover property (@(posedge mclk) $rose(busy_r));
  slow_c: cover property (@(posedge mclk) state_r == sbx_pkg::ST_HIGH && halfDiv == 6'h10);
  done_c: cover property (@(posedge mclk) $rose(transferCompleteFlag_r));
  full_c: cover property (@(posedge mclk) !txReady);
endmodule

// ### test/sbx_slave_model.sv
// Behavioural far-side slave that moves one bit per serial clock.
`timescale 1ns/10ps
module sbx_slave_model (
  input wire logic mclk,
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  input wire logic pol,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte,
  output int rxCount,
  output int edgeCount
);
  logic [7:0] shiftOut = 8'h00;
  logic [3:0] bitCounter = 4'h0;
  logic idleToggle = 1'b0;
  initial begin
    rxByte = 8'h00;
    rxCount = 0;
    edgeCount = 0;
  end
  // A released line must not look like a held bit, so it toggles.
  always @(posedge mclk) idleToggle <= ~idleToggle;
  assign miso = selN ? idleToggle : shiftOut[7];
  always @(negedge selN) begin
    bitCounter = 4'h8;
    shiftOut = txByte;
  end
  always @(sck) begin
    if (!selN && sck != pol) begin
      rxByte = {rxByte[6:0], mosi};
      bitCounter = bitCounter - 4'h1;
      edgeCount++;
      if (bitCounter == 4'h0) rxCount++;
    end else if (!selN) begin
      shiftOut = shiftOut << 1;
    end
  end
endmodule

// ### test/tb.sv
// Self-checking bench for the SPI byte exchange master.
`timescale 1ns/10ps
module tb;
  logic mclk = 0, rst = 1, txValid = 0, rHi = 0, rLo = 0, pol = 0, slvReq = 0, clr = 0;
  logic [7:0] txData = 8'h00, slvTx = 8'h00, rxData, slvRx;
  logic txReady, peerReq, sck, mosi, miso, selN, flag, busy;
  int slvCount, edges, fail_count = 0, compares = 0;
  always #2.5 mclk = ~mclk;
  sbx_master sbx_master_i (.mclk(mclk), .rst(rst), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rateSelectHi(rHi), .rateSelectLo(rLo), .clockIdlePolarity(pol),
    .slaveRequest(slvReq), .transferCompleteClear(clr), .peerRequest_r(peerReq),
    .sck_r(sck), .mosi_r(mosi), .miso(miso), .slaveSelectN_r(selN),
    .transferCompleteFlag_r(flag), .busy_r(busy), .rxData_r(rxData));
  sbx_slave_model sbx_slave_model_i (.mclk(mclk), .sck(sck), .mosi(mosi), .selN(selN),
    .pol(pol), .txByte(slvTx), .miso(miso), .rxByte(slvRx), .rxCount(slvCount),
    .edgeCount(edges));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic push(input logic [7:0] d);
    txData = d;
    txValid = 1;
    while (txReady !== 1'b1) tick(1);
    tick(1);
  endtask
  task automatic exchange(input logic [1:0] r, input logic p, input logic [7:0] d,
      input logic [7:0] s);
    int div, act, bad, n, e0;
    div = r == 0 ? 2 : r == 1 ? 4 : r == 2 ? 16 : 32;
    {rHi, rLo} = r;
    pol = p;
    slvTx = s;
    act = 0;
    bad = 0;
    n = 0;
    tick(2);
    check(sck, p);
    check(peerReq, slvReq);
    e0 = edges;
    push(d);
    txValid = 0;
    while (flag !== 1'b1 && n < 400) begin
      if (sck !== p) act++;
      if (sck !== p && (selN !== 1'b0 || busy !== 1'b1 || peerReq !== 1'b1)) bad++;
      tick(1);
      n++;
    end
    check(bad, 0);
    check(act, 4 * div);
    check(edges - e0, 8);
    check(slvRx, d);
    check(rxData, s);
    check({flag, busy, selN, sck}, {3'b101, p});
    clr = 1;
    tick(1);
    clr = 0;
    check(flag, 0);
    $display("exchange rate %0d polarity %0d done", r, p);
  endtask
  task automatic fill();
    int n0, n;
    n0 = slvCount;
    n = 0;
    {rHi, rLo} = 2'h3;
    for (int i = 0; i < 9; i++) push(8'hA0 + i[7:0]);
    check(txReady, 0);
    push(8'hA9);
    txValid = 0;
    while (slvCount - n0 < 10 && n < 4000) begin
      tick(1);
      n++;
    end
    check(slvCount - n0, 10);
    check(slvRx, 8'hA9);
    $display("fifo fill and drain done");
  endtask
  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    tick(3);
    check({selN, flag, busy, txReady}, 4'h9);
    rst = 0;
    for (int r = 0; r < 4; r++) exchange(r[1:0], r[0], 8'hA5 ^ r[7:0], 8'h3C + r[7:0]);
    slvReq = 1;
    exchange(2'h2, 1'b1, 8'h81, 8'h7E);
    slvReq = 0;
    fill();
    print_verdict();
  end
  // Longest path is the drain at the slowest rate, well under this span.
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
endmodule
